// ===== rtl/xid_pkg.sv
package xid_pkg;
   // register byte offsets
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_INSN = 12'h004;
   localparam logic [11:0] A_STAT = 12'h008;
   localparam logic [11:0] A_WORK = 12'h00c;
   localparam logic [11:0] A_BANK = 12'h010;
   localparam logic [11:0] A_FLAG = 12'h014;
   localparam logic [11:0] A_PTR0 = 12'h018;
   localparam logic [11:0] A_PTR1 = 12'h01c;
   localparam logic [11:0] A_PTR2 = 12'h020;
   localparam logic [11:0] A_PC = 12'h024;
   localparam logic [11:0] A_LATCH = 12'h028;
   localparam logic [11:0] A_RTOP = 12'h02c;
   localparam int MEM_SEL_BIT = 11;
   localparam int MEM_AW = 9;
   localparam int MEM_DEPTH = 512;
   // bit positions and field widths
   localparam int CTRL_EXT = 0;
   localparam int ST_BUSY = 0;
   localparam int ST_WAIT2 = 1;
   localparam int ST_IGN = 2;
   localparam int FL_Z = 2;
   localparam int FL_N = 4;
   localparam int LAT_U_LSB = 8;
   localparam int FLD_D = 9;
   localparam int FLD_A = 8;
   localparam int FLD_PSEL = 6;
   localparam int FLD_MVSEL = 7;
   localparam int K6_W = 6;
   localparam int Z_W = 7;
   localparam int F12_W = 12;
   // four-phase instruction cycle
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam logic [1:0] Q_PRE = 2'h2;
   localparam logic [20:0] PC_STEP1 = 21'h000002;
   localparam logic [20:0] PC_STEP2 = 21'h000004;
   // opcodes and address limits
   localparam logic [5:0] OPC_XOR = 6'h06;
   localparam logic [7:0] OPC_ADDP = 8'he8;
   localparam logic [7:0] OPC_SUBP = 8'he9;
   localparam logic [7:0] OPC_PUSH = 8'hea;
   localparam logic [7:0] OPC_MOVE = 8'heb;
   localparam logic [15:0] OPC_CALL_VIA_WORKING = 16'h0014;
   localparam logic [3:0] WORD2_PFX = 4'hf;
   localparam logic [1:0] PTR_RET = 2'h3;
   localparam logic [7:0] IDX_LIMIT = 8'h5f;
   localparam logic [3:0] ACC_HI = 4'hf;

   typedef enum logic [3:0] {
      OP_NONE, OP_XOR_FILE, OP_ADD_PTR, OP_SUB_PTR, OP_ADD_RET,
      OP_SUB_RET, OP_CALL_W, OP_MV_IDX_FILE, OP_MV_IDX_IDX, OP_PUSH_LIT
   } xid_op_t;
endpackage

// ===== rtl/xid_dec_if.sv
`timescale 1ns/1ns
interface xid_dec_if;
   import xid_pkg::*;
   logic [15:0] word1;
   logic ext_en;
   xid_op_t op;
   logic two_word;
   logic two_cycle;
   logic ind_mode;
   modport dec(input word1, ext_en,
      output op, two_word, two_cycle, ind_mode);
   modport core(output word1, ext_en,
      input op, two_word, two_cycle, ind_mode);
endinterface

// ===== rtl/xid_decode.sv
`timescale 1ns/1ns
module xid_decode (
   // decode request and result
   xid_dec_if.dec bus
);
   import xid_pkg::*;
   logic [1:0] psel;

   always_comb begin
      psel = bus.word1[FLD_PSEL +: 2];
      bus.op = OP_NONE;
      bus.two_word = 1'b0;
      bus.two_cycle = 1'b0;
      if (bus.word1[15:10] == OPC_XOR) begin
         bus.op = OP_XOR_FILE;
      end else if (bus.ext_en && bus.word1 == OPC_CALL_VIA_WORKING) begin
         bus.op = OP_CALL_W;
         bus.two_cycle = 1'b1;
      end else if (bus.ext_en) begin
         unique case (bus.word1[15:8])
            OPC_ADDP: begin
               bus.op = (psel == PTR_RET) ? OP_ADD_RET : OP_ADD_PTR;
               bus.two_cycle = (psel == PTR_RET);
            end
            OPC_SUBP: begin
               bus.op = (psel == PTR_RET) ? OP_SUB_RET : OP_SUB_PTR;
               bus.two_cycle = (psel == PTR_RET);
            end
            OPC_PUSH: bus.op = OP_PUSH_LIT;
            OPC_MOVE: begin
               bus.op = bus.word1[FLD_MVSEL] ? OP_MV_IDX_IDX
                  : OP_MV_IDX_FILE;
               bus.two_word = 1'b1;
               bus.two_cycle = 1'b1;
            end
            default: bus.op = OP_NONE;
         endcase
      end
      bus.ind_mode = (bus.op == OP_XOR_FILE) && bus.ext_en &&
         !bus.word1[FLD_A] && (bus.word1[7:0] <= IDX_LIMIT);
   end
endmodule // xid_decode

// ===== rtl/xid_core.sv
// How it works
// - xor instruction combines working register with the addressed file byte
// - destination bit 0 writes working register, 1 writes the file byte
// - access bit 0 uses access bank, 1 uses bank select register
// - access bit 0, extension on, address up to 5f: offset from pointer 2
// - xor updates only negative and zero flags from its result
// - xor opcode is 000110 d a f8, one word, one cycle
// - extension and indexed offset mode are off after reset until enabled
// - extension adds exactly eight instructions, seven of them on the pointer registers
// - add or subtract 6-bit literal to pointer 0..2, one cycle, no flags
// - add with pointer select 3 adds to pointer 2 then returns, two cycles
// - subtract with pointer select 3 subtracts from pointer 2 then returns
// - word 0014 calls with low target byte from working register, two cycles
// - indexed-to-file move: two words, source pointer-2 offset, 12-bit target
// - indexed-to-indexed move: two words, both offsets from pointer 2
// - push literal stores at pointer 2 then decrements it, one cycle
// - add-and-return loads program counter from stack top, nop second cycle
// - register call pushes next address, loads pc from working reg and latches
`timescale 1ns/1ns
module xid_core (
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [11:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // configuration state
   output logic EXT_EN
);
   import xid_pkg::*;

   typedef struct packed {
      logic [1:0] q;
      logic ext_en;
      logic [7:0] w;
      logic [3:0] bank;
      logic neg;
      logic zero;
      logic [2:0][11:0] ptr;
      logic [20:0] pc;
      logic [7:0] pch_l;
      logic [4:0] pcu_l;
      logic [20:0] rtop;
      logic [15:0] word1;
      logic [15:0] word2;
      logic have1;
      logic have2;
      logic stall;
      logic ign;
      logic ack;
      logic [31:0] dato;
   } xid_st_t;

   localparam xid_st_t ST_RST = '0;

   xid_st_t st_r, st_nxt;
   logic [7:0] mem [MEM_DEPTH];
   logic mem_we;
   logic [MEM_AW-1:0] mem_wa;
   logic [7:0] mem_wd;
   xid_dec_if dif();

   xid_decode u_dec (
      .bus(dif.dec)
   );

   assign dif.word1 = st_r.word1;
   assign dif.ext_en = st_r.ext_en;

   // instruction fields
   logic d_bit, a_bit;
   logic [7:0] f8, k8;
   logic [1:0] psel;
   logic [K6_W-1:0] k6;
   logic [Z_W-1:0] zs, zd;
   logic [F12_W-1:0] f12;
   assign d_bit = st_r.word1[FLD_D];
   assign a_bit = st_r.word1[FLD_A];
   assign f8 = st_r.word1[7:0];
   assign k8 = st_r.word1[7:0];
   assign psel = st_r.word1[FLD_PSEL +: 2];
   assign k6 = st_r.word1[0 +: K6_W];
   assign zs = st_r.word1[0 +: Z_W];
   assign zd = st_r.word2[0 +: Z_W];
   assign f12 = st_r.word2[0 +: F12_W];

   // operand addressing
   logic [11:0] xaddr, src_a, dst_a, sel_ptr;
   logic [MEM_AW-1:0] xidx, sidx;
   logic [7:0] xor_res, src_data;
   logic xor_zero;

   always_comb begin
      if (a_bit) begin
         xaddr = {st_r.bank, f8};
      end else if (dif.ind_mode) begin
         xaddr = st_r.ptr[2] + 12'(f8);
      end else if (f8 <= IDX_LIMIT) begin
         xaddr = 12'(f8);
      end else begin
         xaddr = {ACC_HI, f8};
      end
   end

   assign xidx = xaddr[MEM_AW-1:0];
   assign xor_res = st_r.w ^ mem[xidx];
   assign xor_zero = (xor_res == 8'h00);
   assign src_a = st_r.ptr[2] + 12'(zs);
   assign sidx = src_a[MEM_AW-1:0];
   assign src_data = mem[sidx];
   assign dst_a = (dif.op == OP_MV_IDX_FILE) ? f12
      : st_r.ptr[2] + 12'(zd);
   assign sel_ptr = (psel == 2'h0) ? st_r.ptr[0]
      : (psel == 2'h1) ? st_r.ptr[1] : st_r.ptr[2];

   // bus side
   logic bus_req, bus_wr, is_mem;
   logic [31:0] rd_val, wmerge;
   assign bus_req = CYC_I && STB_I;
   assign bus_wr = bus_req && WE_I && st_r.ack;
   assign is_mem = ADR_I[MEM_SEL_BIT];

   always_comb begin
      rd_val = '0;
      if (is_mem) begin
         rd_val[7:0] = mem[ADR_I[2 +: MEM_AW]];
      end else begin
         case (ADR_I)
            A_CTRL: rd_val[CTRL_EXT] = st_r.ext_en;
            A_INSN: rd_val[15:0] = st_r.word1;
            A_STAT: begin
               rd_val[ST_BUSY] = st_r.have1 || st_r.stall;
               rd_val[ST_WAIT2] = st_r.have1 && dif.two_word &&
                  !st_r.have2;
               rd_val[ST_IGN] = st_r.ign;
            end
            A_WORK: rd_val[7:0] = st_r.w;
            A_BANK: rd_val[3:0] = st_r.bank;
            A_FLAG: begin
               rd_val[FL_N] = st_r.neg;
               rd_val[FL_Z] = st_r.zero;
            end
            A_PTR0: rd_val[11:0] = st_r.ptr[0];
            A_PTR1: rd_val[11:0] = st_r.ptr[1];
            A_PTR2: rd_val[11:0] = st_r.ptr[2];
            A_PC: rd_val[20:0] = st_r.pc;
            A_LATCH: begin
               rd_val[7:0] = st_r.pch_l;
               rd_val[LAT_U_LSB +: 5] = st_r.pcu_l;
            end
            A_RTOP: rd_val[20:0] = st_r.rtop;
            default: rd_val = '0;
         endcase
      end
   end

   // unselected byte lanes keep their value
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wmerge[8*b +: 8] = SEL_I[b] ? DAT_I[8*b +: 8]
         : rd_val[8*b +: 8];
   end

   // execution slot: the Q4 phase is the instruction-cycle enable
   logic go;
   assign go = (st_r.q == Q_LAST) && st_r.have1 && !st_r.stall &&
      (!dif.two_word || st_r.have2);

   always_comb begin
      st_nxt = st_r;
      mem_we = 1'b0;
      mem_wa = '0;
      mem_wd = '0;
      st_nxt.q = st_r.q + 2'h1;
      // never ack into the Q4 edge, so bus and core never collide
      st_nxt.ack = bus_req && !st_r.ack && (st_r.q != Q_PRE);
      if (bus_req && !st_r.ack) begin
         st_nxt.dato = rd_val;
      end
      if (st_r.stall && st_r.q == Q_LAST) begin
         st_nxt.stall = 1'b0;
      end
      if (bus_wr) begin
         if (is_mem) begin
            mem_we = SEL_I[0];
            mem_wa = ADR_I[2 +: MEM_AW];
            mem_wd = DAT_I[7:0];
         end
         case (ADR_I)
            A_CTRL: st_nxt.ext_en = wmerge[CTRL_EXT];
            A_INSN: begin
               if (!st_r.have1 && !st_r.stall) begin
                  st_nxt.word1 = wmerge[15:0];
                  st_nxt.have1 = 1'b1;
               end else if (st_r.have1 && dif.two_word &&
                  !st_r.have2) begin
                  if (wmerge[15:12] == WORD2_PFX) begin
                     st_nxt.word2 = wmerge[15:0];
                     st_nxt.have2 = 1'b1;
                  end else begin
                     // malformed pair is dropped whole
                     st_nxt.have1 = 1'b0;
                     st_nxt.ign = 1'b1;
                  end
               end else begin
                  st_nxt.ign = 1'b1;
               end
            end
            A_STAT: begin
               if (wmerge[ST_IGN]) begin
                  st_nxt.ign = 1'b0;
               end
            end
            A_WORK: st_nxt.w = wmerge[7:0];
            A_BANK: st_nxt.bank = wmerge[3:0];
            A_FLAG: begin
               st_nxt.neg = wmerge[FL_N];
               st_nxt.zero = wmerge[FL_Z];
            end
            A_PTR0: st_nxt.ptr[0] = wmerge[11:0];
            A_PTR1: st_nxt.ptr[1] = wmerge[11:0];
            A_PTR2: st_nxt.ptr[2] = wmerge[11:0];
            A_PC: st_nxt.pc = wmerge[20:0];
            A_LATCH: begin
               st_nxt.pch_l = wmerge[7:0];
               st_nxt.pcu_l = wmerge[LAT_U_LSB +: 5];
            end
            A_RTOP: st_nxt.rtop = wmerge[20:0];
            default: st_nxt.ign = st_r.ign;
         endcase
      end
      if (go) begin
         st_nxt.have1 = 1'b0;
         st_nxt.have2 = 1'b0;
         st_nxt.stall = dif.two_cycle;
         st_nxt.pc = st_r.pc + (dif.two_word ? PC_STEP2 : PC_STEP1);
         unique case (dif.op)
            OP_XOR_FILE: begin
               st_nxt.neg = xor_res[7];
               st_nxt.zero = xor_zero;
               if (!d_bit) begin
                  st_nxt.w = xor_res;
               end else begin
                  mem_we = 1'b1;
                  mem_wa = xidx;
                  mem_wd = xor_res;
               end
            end
            OP_ADD_PTR, OP_SUB_PTR: begin
               for (int i = 0; i < 3; i++) begin
                  if (psel == 2'(i)) begin
                     st_nxt.ptr[i] = (dif.op == OP_ADD_PTR)
                        ? st_r.ptr[i] + 12'(k6)
                        : st_r.ptr[i] - 12'(k6);
                  end
               end
            end
            OP_ADD_RET: begin
               st_nxt.ptr[2] = st_r.ptr[2] + 12'(k6);
               st_nxt.pc = st_r.rtop;
            end
            OP_SUB_RET: begin
               st_nxt.ptr[2] = st_r.ptr[2] - 12'(k6);
               st_nxt.pc = st_r.rtop;
            end
            OP_CALL_W: begin
               st_nxt.rtop = st_r.pc + PC_STEP1;
               st_nxt.pc = {st_r.pcu_l, st_r.pch_l, st_r.w};
            end
            OP_MV_IDX_FILE, OP_MV_IDX_IDX: begin
               mem_we = 1'b1;
               mem_wa = dst_a[MEM_AW-1:0];
               mem_wd = src_data;
            end
            OP_PUSH_LIT: begin
               mem_we = 1'b1;
               mem_wa = st_r.ptr[2][MEM_AW-1:0];
               mem_wd = k8;
               st_nxt.ptr[2] = st_r.ptr[2] - 12'h001;
            end
            OP_NONE: st_nxt.ign = 1'b1;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // data memory carries no reset
   always_ff @(posedge CLK) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign DAT_O = st_r.dato;
   assign ACK_O = st_r.ack;
   assign EXT_EN = st_r.ext_en;

   // checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   logic ex_xor, ex_ptr, ex_ret, ex_call, ex_push, ex_mv, ex_ext;
   assign ex_xor = go && dif.op == OP_XOR_FILE;
   assign ex_ptr = go && dif.op == OP_ADD_PTR;
   assign ex_ret = go && dif.op == OP_ADD_RET;
   assign ex_call = go && dif.op == OP_CALL_W;
   assign ex_push = go && dif.op == OP_PUSH_LIT;
   assign ex_mv = go && dif.op == OP_MV_IDX_FILE;
   assign ex_ext = go && dif.op != OP_XOR_FILE && dif.op != OP_NONE;

   sequence s_nop_cycle;
      st_r.stall [*4] ##1 !st_r.stall;
   endsequence

   sequence s_one_cycle;
      !st_r.stall [*4];
   endsequence

   AST_XOR_W: assert property (ex_xor && !d_bit |=>
      st_r.w == $past(xor_res))
      else $error("xor result missing from working register");
   AST_XOR_F: assert property (ex_xor && d_bit |=>
      mem[$past(xidx)] == $past(xor_res) && $stable(st_r.w))
      else $error("xor result missing from file byte");
   AST_FLAGS: assert property (ex_xor |=>
      st_r.zero == $past(xor_zero) && st_r.neg == $past(xor_res[7]))
      else $error("xor flags wrong");
   AST_IDX: assert property (ex_xor && !a_bit && st_r.ext_en &&
      f8 <= IDX_LIMIT |-> xaddr == st_r.ptr[2] + 12'(f8))
      else $error("indexed offset address wrong");
   AST_PTR: assert property (ex_ptr |=>
      sel_ptr == $past(sel_ptr) + 12'($past(k6)) &&
      $stable(st_r.zero) ##0 s_one_cycle)
      else $error("pointer add wrong");
   AST_RET: assert property (ex_ret |=>
      st_r.pc == $past(st_r.rtop) ##0 s_nop_cycle)
      else $error("add and return wrong");
   AST_CALL: assert property (ex_call |=>
      st_r.rtop == $past(st_r.pc) + PC_STEP1 &&
      st_r.pc[7:0] == $past(st_r.w) ##0 s_nop_cycle)
      else $error("register call wrong");
   AST_PUSH: assert property (ex_push |=>
      st_r.ptr[2] == $past(st_r.ptr[2]) - 12'h001 &&
      mem[$past(st_r.ptr[2][MEM_AW-1:0])] == $past(k8))
      else $error("push literal wrong");
   AST_MOVE: assert property (ex_mv |=>
      mem[$past(dst_a[MEM_AW-1:0])] == $past(src_data))
      else $error("indexed move wrong");
   AST_EXT_OFF: assert property (!st_r.ext_en |->
      !ex_ext && !dif.ind_mode)
      else $error("extension active while disabled");
   AST_ACK: assert property (bus_req && !st_r.ack ##1 bus_req |->
      ##[0:1] st_r.ack)
      else $error("bus answer late");
endmodule // xid_core

// ===== verif/xid_prog_mem.sv
`timescale 1ns/1ns
module xid_prog_mem (
   // word fetch
   input wire logic [3:0] addr,
   output logic [15:0] word
);
   logic [15:0] rom [16];
   initial begin
      rom = '{16'h1b10, 16'h1820, 16'h1805, 16'h1860, 16'he8e3, 16'he9e3,
         16'h0014, 16'hea77, 16'heb05, 16'hf123, 16'heb86, 16'hf00a,
         16'h1234, 16'he823, 16'h0000, 16'h0000};
   end
   assign word = rom[addr];
endmodule // xid_prog_mem

// ===== verif/tb.sv
`timescale 1ns/1ns
module tb;
   import xid_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [11:0] adr_i = 12'h000;
   logic [3:0] sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic ext_en;
   logic [3:0] pm_addr = 4'h0;
   logic [15:0] pm_word;
   int err_count = 0;
   int check_count = 0;
   int cyc_cnt = 0;

   xid_core dut_u (.CLK(clk), .NRST(nrst), .CYC_I(cyc_i), .STB_I(stb_i),
      .WE_I(we_i), .ADR_I(adr_i), .SEL_I(sel_i), .DAT_I(dat_i),
      .DAT_O(dat_o), .ACK_O(ack_o), .EXT_EN(ext_en));
   xid_prog_mem pm_u (.addr(pm_addr), .word(pm_word));

   always #5 clk = ~clk;

   task automatic finish_test();
      if (err_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // hang guard, the whole run needs well under 3000 cycles
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 8000) begin
         err_count++;
         $display("MISMATCH %0t timeout", $time);
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic [11:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      // ack is sampled at the edge, before that edge's updates land
      do begin
         @(posedge clk);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50)
         chk(32'h0, 32'h1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(a, 1'b1, d, q);
   endtask

   task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(a, 1'b0, 32'h0, q);
      chk(q, exp);
   endtask

   function automatic logic [11:0] ma(input logic [8:0] i);
      return {1'b1, i, 2'b00};
   endfunction

   // execution waits for a q3 edge and may hold a nop cycle: 10 covers both
   task automatic exec(input logic [15:0] w);
      wr(A_INSN, {16'h0, w});
      repeat (10) @(posedge clk);
   endtask

   task automatic run(input logic [3:0] idx);
      pm_addr = idx;
      @(posedge clk);
      exec(pm_word);
   endtask

   task automatic t_reset();
      chk({31'h0, ext_en}, 32'h0);
      chk_rd(A_CTRL, 32'h0);
      chk_rd(A_STAT, 32'h0);
      wr(12'h0c0, 32'hff);
      chk_rd(12'h0c0, 32'h0);
   endtask

   task automatic t_xor_bank();
      wr(A_BANK, 32'h1);
      wr(A_WORK, 32'hb5);
      wr(A_FLAG, 32'h14);
      wr(ma(9'h110), 32'haf);
      run(4'h0);
      chk_rd(ma(9'h110), 32'h1a);
      chk_rd(A_WORK, 32'hb5);
      chk_rd(A_FLAG, 32'h00);
      chk_rd(A_PC, 32'h2);
   endtask

   task automatic t_xor_access();
      wr(A_PTR2, 32'h080);
      wr(ma(9'h020), 32'h0f);
      wr(ma(9'h0a0), 32'h00);
      wr(A_WORK, 32'h8f);
      run(4'h1);
      chk_rd(A_WORK, 32'h80);
      chk_rd(A_FLAG, 32'h10);
      chk_rd(ma(9'h020), 32'h0f);
   endtask

   task automatic t_xor_index();
      wr(A_CTRL, 32'h1);
      // the write lands at the ack edge, so look one edge later
      @(posedge clk);
      chk({31'h0, ext_en}, 32'h1);
      wr(ma(9'h085), 32'h3c);
      wr(ma(9'h005), 32'h99);
      wr(A_WORK, 32'h3c);
      run(4'h2);
      chk_rd(A_WORK, 32'h0);
      chk_rd(A_FLAG, 32'h04);
      // first address past the indexed range goes back to the access bank
      wr(ma(9'h160), 32'h55);
      wr(ma(9'h0e0), 32'haa);
      wr(A_WORK, 32'h0);
      run(4'h3);
      chk_rd(A_WORK, 32'h55);
      chk_rd(A_FLAG, 32'h00);
   endtask

   task automatic t_ptr();
      logic [11:0] pa;
      // both flags set, so any flag write by the pointer ops shows
      wr(A_FLAG, 32'h14);
      for (int p = 0; p < 3; p++) begin
         pa = A_PTR0 + 12'(4 * p);
         wr(pa, 32'h3ff);
         exec({OPC_ADDP, 2'(p), 6'h23});
         chk_rd(pa, 32'h422);
         exec({OPC_SUBP, 2'(p), 6'h23});
         chk_rd(pa, 32'h3ff);
      end
      chk_rd(A_FLAG, 32'h14);
   endtask

   task automatic t_ret();
      wr(A_PTR2, 32'h3ff);
      wr(A_RTOP, 32'h200);
      wr(A_PC, 32'h100);
      run(4'h4);
      chk_rd(A_PTR2, 32'h422);
      chk_rd(A_PC, 32'h200);
      wr(A_RTOP, 32'h300);
      run(4'h5);
      chk_rd(A_PTR2, 32'h3ff);
      chk_rd(A_PC, 32'h300);
      chk_rd(A_FLAG, 32'h14);
   endtask

   task automatic t_call_via_working();
      wr(A_PC, 32'h100);
      wr(A_WORK, 32'h40);
      wr(A_LATCH, 32'h0312);
      run(4'h6);
      chk_rd(A_RTOP, 32'h102);
      chk_rd(A_PC, 32'h031240);
      chk_rd(A_FLAG, 32'h14);
   endtask

   task automatic t_push();
      wr(A_PTR2, 32'h050);
      wr(ma(9'h050), 32'h0);
      run(4'h7);
      chk_rd(ma(9'h050), 32'h77);
      chk_rd(A_PTR2, 32'h04f);
   endtask

   task automatic t_move();
      wr(A_PTR2, 32'h080);
      wr(ma(9'h085), 32'h5a);
      wr(ma(9'h123), 32'h0);
      run(4'h8);
      chk_rd(A_STAT, 32'h3);
      run(4'h9);
      chk_rd(ma(9'h123), 32'h5a);
      wr(ma(9'h086), 32'hc3);
      wr(ma(9'h08a), 32'h0);
      run(4'ha);
      run(4'hb);
      chk_rd(ma(9'h08a), 32'hc3);
      // a second word without the f prefix must drop the pair
      wr(ma(9'h123), 32'h0);
      run(4'h8);
      run(4'hc);
      chk_rd(A_STAT, 32'h4);
      chk_rd(ma(9'h123), 32'h0);
      wr(A_STAT, 32'h4);
      chk_rd(A_STAT, 32'h0);
   endtask

   task automatic t_off();
      wr(A_CTRL, 32'h0);
      @(posedge clk);
      chk({31'h0, ext_en}, 32'h0);
      wr(A_PTR0, 32'h010);
      run(4'hd);
      chk_rd(A_PTR0, 32'h010);
      chk_rd(A_STAT, 32'h4);
      wr(A_STAT, 32'h4);
   endtask

   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_xor_bank();
      t_xor_access();
      t_xor_index();
      t_ptr();
      t_ret();
      t_call_via_working();
      t_push();
      t_move();
      t_off();
      finish_test();
   end
endmodule // tb
